/* design/bms_top.sv */
// Boot mode select with mode latch, boot ROM enable, vector relocation and autobaud
`timescale 1ns/100ps

// Summary of operation
// - The mode-A pin is latched into the expanded select bit at reset release.
// - The special select bit is loaded with the inverted mode-B pin at reset release.
// - Pin pairs decode to the four modes and only special bootstrap enables the boot ROM.
// - Boot ROM enable is writable only in special modes and reads zero in normal modes.
// - The boot ROM is mapped only while its enable bit is set.
// - Boot ROM enable resets to one in special bootstrap and zero otherwise.
// - In special modes address line 14 is forced low on vector fetches.
// - Mode control bits are software writable only in special modes.
// - With security programmed the mode-A pin is ignored and mode-B alone selects the mode.
// - The receiver confirms the start bit at mid-bit, samples data mid-bit and checks the stop bit.
// - A first character of C0 or E0 selects the slow rate.
// - A first character of all ones keeps the default rate.
module bms_top (
  input wire logic CORE_CLK,
  input wire logic RESETN,
  input wire logic CLK_EN,
  input wire logic MODE_PIN_A,
  input wire logic MODE_PIN_B,
  input wire logic SECURITY_DISABLE_BIT,
  input wire logic RXD,
  input wire logic VEC_FETCH,
  input wire logic [15:0] CPU_ADDR,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [15:0] MEM_ADDR,
  output logic BOOT_ROM_SEL,
  output logic EXPANDED_SELECT_BIT,
  output logic SPECIAL_SELECT_BIT,
  output logic BOOT_ROM_ENABLE_BIT,
  output logic SLOW_BAUD
);
  typedef struct packed {
    logic strap_done;
    logic exp;
    logic spc;
    logic boot;
    logic slow;
    logic first_seen;
    logic ferr;
    logic rxv;
    logic [7:0] rxdata;
    logic wreq;
    logic [31:0] rdata;
    logic [15:0] addr;
    logic rom_sel;
  } bms_s_t;

  // Waitrequest idles high, so it leaves reset high as well
  localparam bms_s_t RST_S = '{wreq: 1'b1, default: '0};
  bms_s_t s_reg;
  bms_s_t s_next;
  logic rx_done;
  logic rx_ferr;
  logic [7:0] rx_data;
  logic req;
  logic wr_mode;
  logic strap_exp;
  logic strap_spc;

  bms_rx u_rx (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .ce(CLK_EN),
    .slow(s_reg.slow),
    .rxd(RXD),
    .done(rx_done),
    .ferr(rx_ferr),
    .data(rx_data)
  );

  always_comb
  begin
    s_next = s_reg;
    // Waitrequest drops for the one cycle after a request is taken
    req = (AVS_READ || AVS_WRITE) && s_reg.wreq;
    s_next.wreq = !req;
    // Security forces the single-chip side of the pin pair
    strap_exp = SECURITY_DISABLE_BIT ? MODE_PIN_A : 1'b0;
    strap_spc = !MODE_PIN_B;
    if (!s_reg.strap_done)
    begin
      // Strap caught on the first enabled edge after release
      s_next.strap_done = 1'b1;
      s_next.exp = strap_exp;
      s_next.spc = strap_spc;
      s_next.boot = strap_spc && !strap_exp;
    end
    wr_mode = req && AVS_WRITE && AVS_ADDRESS == bms_pkg::OFS_MODE && AVS_BYTEENABLE[0] && s_reg.strap_done;
    if (wr_mode && s_reg.spc)
    begin
      s_next.exp = AVS_WRITEDATA[bms_pkg::BIT_EXP];
      s_next.spc = AVS_WRITEDATA[bms_pkg::BIT_SPC];
      // Enable never outlives special select, so it is gated by the written select bit
      s_next.boot = AVS_WRITEDATA[bms_pkg::BIT_BOOT] && AVS_WRITEDATA[bms_pkg::BIT_SPC];
    end
    // Leaving special mode drops the boot ROM enable
    if (s_reg.strap_done && !s_reg.spc)
      s_next.boot = 1'b0;
    if (rx_done)
    begin
      s_next.rxdata = rx_data;
      s_next.rxv = 1'b1;
      s_next.ferr = rx_ferr;
      if (!s_reg.first_seen)
      begin
        s_next.first_seen = 1'b1;
        if (rx_data == bms_pkg::CHAR_SLOW_A || rx_data == bms_pkg::CHAR_SLOW_B)
          s_next.slow = 1'b1;
        else if (rx_data == bms_pkg::CHAR_ONES)
          s_next.slow = 1'b0;
      end
    end
    else if (req && AVS_READ && AVS_ADDRESS == bms_pkg::OFS_RXDATA)
      s_next.rxv = 1'b0;
    if (req && AVS_READ)
    begin
      case (AVS_ADDRESS)
        bms_pkg::OFS_MODE:
          s_next.rdata = {28'h0000000, !SECURITY_DISABLE_BIT, s_reg.boot && s_reg.spc, s_reg.spc, s_reg.exp};
        bms_pkg::OFS_BAUD:
          s_next.rdata = {28'h0000000, s_reg.rxv, s_reg.ferr, s_reg.first_seen, s_reg.slow};
        bms_pkg::OFS_RXDATA:
          s_next.rdata = {24'h000000, s_reg.rxdata};
        default:
          s_next.rdata = 32'h00000000;
      endcase
    end
    s_next.addr = CPU_ADDR;
    if (VEC_FETCH && s_reg.spc)
      s_next.addr[bms_pkg::VEC_ADDR_BIT] = 1'b0;
    s_next.rom_sel = s_reg.boot && s_reg.spc;
  end

  always_ff @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      s_reg <= RST_S;
    else if (CLK_EN)
      s_reg <= s_next;
  end

  // Wait one cycle so read data comes straight from a flop
  assign AVS_WAITREQUEST = s_reg.wreq;
  assign AVS_READDATA = s_reg.rdata;
  assign MEM_ADDR = s_reg.addr;
  assign BOOT_ROM_SEL = s_reg.rom_sel;
  assign EXPANDED_SELECT_BIT = s_reg.exp;
  assign SPECIAL_SELECT_BIT = s_reg.spc;
  assign BOOT_ROM_ENABLE_BIT = s_reg.boot;
  assign SLOW_BAUD = s_reg.slow;

  // Strap capture; sampled RESETN keeps the release edge itself out, the design is still in reset there
  a_strap_latch: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (RESETN && CLK_EN && !s_reg.strap_done)
    |=> (EXPANDED_SELECT_BIT == ($past(MODE_PIN_A) && $past(SECURITY_DISABLE_BIT))))
    else $error("expanded select not latched from pin");

  a_special_inv: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (RESETN && CLK_EN && !s_reg.strap_done)
    |=> (SPECIAL_SELECT_BIT == !$past(MODE_PIN_B)))
    else $error("special select not inverse of pin");

  a_mode_decode: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (RESETN && CLK_EN && !s_reg.strap_done && SECURITY_DISABLE_BIT && !MODE_PIN_B && MODE_PIN_A)
    |=> (EXPANDED_SELECT_BIT && SPECIAL_SELECT_BIT && !BOOT_ROM_ENABLE_BIT))
    else $error("special test decode wrong");

  a_expand_decode: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (RESETN && CLK_EN && !s_reg.strap_done && SECURITY_DISABLE_BIT && MODE_PIN_B && MODE_PIN_A)
    |=> (EXPANDED_SELECT_BIT && !SPECIAL_SELECT_BIT && !BOOT_ROM_ENABLE_BIT))
    else $error("normal expanded decode wrong");

  a_boot_reset: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (RESETN && CLK_EN && !s_reg.strap_done && (MODE_PIN_B || (MODE_PIN_A && SECURITY_DISABLE_BIT)))
    |=> !BOOT_ROM_ENABLE_BIT)
    else $error("boot enable set outside bootstrap");

  a_boot_set: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (RESETN && CLK_EN && !s_reg.strap_done && !MODE_PIN_B && !(MODE_PIN_A && SECURITY_DISABLE_BIT))
    |=> BOOT_ROM_ENABLE_BIT)
    else $error("boot enable clear in bootstrap");

  a_sec_ignore: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (RESETN && CLK_EN && !s_reg.strap_done && !SECURITY_DISABLE_BIT)
    |=> !EXPANDED_SELECT_BIT)
    else $error("mode pin a not ignored when secured");

  a_mode_hold: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (s_reg.strap_done && !s_reg.spc)
    |=> ($stable(s_reg.exp) && !s_reg.spc))
    else $error("mode bits changed in normal mode");

  // Software writes to the mode word, taken only in special modes
  a_spc_wr_set: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && s_reg.wreq && AVS_WRITE && AVS_ADDRESS == 4'h0 && AVS_BYTEENABLE[0] && s_reg.strap_done &&
      s_reg.spc && AVS_WRITEDATA[1])
    |=> SPECIAL_SELECT_BIT)
    else $error("special select write lost");

  a_spc_wr_clr: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && s_reg.wreq && AVS_WRITE && AVS_ADDRESS == 4'h0 && AVS_BYTEENABLE[0] && s_reg.strap_done &&
      s_reg.spc && !AVS_WRITEDATA[1])
    |=> !SPECIAL_SELECT_BIT)
    else $error("special select clear lost");

  a_exp_wr_set: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && s_reg.wreq && AVS_WRITE && AVS_ADDRESS == 4'h0 && AVS_BYTEENABLE[0] && s_reg.strap_done &&
      s_reg.spc && AVS_WRITEDATA[0])
    |=> EXPANDED_SELECT_BIT)
    else $error("expanded select write lost");

  a_boot_wr_set: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && s_reg.wreq && AVS_WRITE && AVS_ADDRESS == 4'h0 && AVS_BYTEENABLE[0] && s_reg.strap_done &&
      s_reg.spc && AVS_WRITEDATA[1] && AVS_WRITEDATA[2])
    |=> BOOT_ROM_ENABLE_BIT)
    else $error("boot enable write lost");

  a_boot_normal: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (s_reg.strap_done && !s_reg.spc)
    |-> !BOOT_ROM_ENABLE_BIT)
    else $error("boot enable set in normal mode");

  // Memory map and vector fetches
  a_rom_map: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && s_reg.strap_done)
    |=> (BOOT_ROM_SEL == $past(BOOT_ROM_ENABLE_BIT)))
    else $error("boot rom map does not follow enable");

  a_rom_unmap: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && !BOOT_ROM_ENABLE_BIT)
    |=> !BOOT_ROM_SEL)
    else $error("boot rom mapped while disabled");

  a_vec_reloc: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && VEC_FETCH && s_reg.spc)
    |=> !MEM_ADDR[14])
    else $error("vector address line not forced low");

  a_vec_normal: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (RESETN && CLK_EN && VEC_FETCH && !s_reg.spc)
    |=> (MEM_ADDR == $past(CPU_ADDR)))
    else $error("vector moved in normal mode");

  a_addr_pass: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (RESETN && CLK_EN && !VEC_FETCH)
    |=> (MEM_ADDR == $past(CPU_ADDR)))
    else $error("plain fetch address altered");

  // First character and rate choice
  a_slow_pick: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && rx_done && !s_reg.first_seen && (rx_data == 8'hC0 || rx_data == 8'hE0))
    |=> SLOW_BAUD)
    else $error("slow rate not selected");

  a_first_mark: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && rx_done)
    |=> s_reg.first_seen)
    else $error("first character not marked");

  a_fast_keep: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && rx_done && !s_reg.first_seen && rx_data == 8'hFF)
    |=> !SLOW_BAUD)
    else $error("default rate not kept");

  a_rate_hold: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && s_reg.first_seen)
    |=> $stable(SLOW_BAUD))
    else $error("rate changed after first character");

  a_rx_flag: assert property (
    @(posedge CORE_CLK) disable iff (!RESETN)
    (CLK_EN && rx_done)
    |=> (s_reg.rxv && (s_reg.ferr == $past(rx_ferr))))
    else $error("received character not flagged");
endmodule

/* design/bms_pkg.sv */
// Package of constants and types for the boot mode select and autobaud block
package bms_pkg;
  // Register word offsets (byte addresses)
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_BAUD = 4'h4;
  localparam logic [3:0] OFS_RXDATA = 4'h8;
  // Field positions in mode register
  localparam int BIT_EXP = 0;
  localparam int BIT_SPC = 1;
  localparam int BIT_BOOT = 2;
  localparam int BIT_SEC = 3;
  // Field positions in baud/status register
  localparam int BIT_SLOW = 0;
  localparam int BIT_FIRST = 1;
  localparam int BIT_FERR = 2;
  localparam int BIT_RXV = 3;
  // Bit times counted in core clocks for the default and the slow rate
  localparam int E_CLK_HZ = 25000000;
  localparam int BAUD_FAST = 7812;
  localparam int BAUD_SLOW = 1200;
  localparam int BIT_CYC_FAST = E_CLK_HZ / BAUD_FAST;
  localparam int BIT_CYC_SLOW = E_CLK_HZ / BAUD_SLOW;
  localparam logic [7:0] CHAR_ONES = 8'hFF;
  localparam logic [7:0] CHAR_SLOW_A = 8'hC0;
  localparam logic [7:0] CHAR_SLOW_B = 8'hE0;
  // Vector fetch address line forced low in special modes
  localparam int VEC_ADDR_BIT = 14;
  typedef enum logic [3:0] {
    BMS_IDLE = 4'h1,
    BMS_START = 4'h2,
    BMS_DATA = 4'h4,
    BMS_STOP = 4'h8
  } bms_rx_state_t;
endpackage

/* design/bms_rx.sv */
// Serial receiver with start confirm, mid-bit sampling and stop framing check
`timescale 1ns/100ps
module bms_rx #(
  parameter int FAST_CYC = bms_pkg::BIT_CYC_FAST,
  parameter int SLOW_CYC = bms_pkg::BIT_CYC_SLOW
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic slow,
  input wire logic rxd,
  output logic done,
  output logic ferr,
  output logic [7:0] data
);
  typedef struct packed {
    bms_pkg::bms_rx_state_t st;
    logic [15:0] cnt;
    logic [2:0] idx;
    logic [7:0] sh;
    logic rxd_d;
    logic done;
    logic ferr;
    logic [7:0] data;
  } bms_rx_s_t;

  bms_rx_s_t s_reg;
  bms_rx_s_t s_next;
  logic [15:0] bit_cyc;
  logic [15:0] half_cyc;

  always_comb
  begin
    bit_cyc = slow ? 16'(SLOW_CYC) : 16'(FAST_CYC);
    half_cyc = {1'b0, bit_cyc[15:1]};
    s_next = s_reg;
    s_next.rxd_d = rxd;
    s_next.done = 1'b0;
    case (s_reg.st)
      bms_pkg::BMS_IDLE:
      begin
        // Falling edge of start bit
        if (s_reg.rxd_d && !rxd)
        begin
          s_next.st = bms_pkg::BMS_START;
          s_next.cnt = half_cyc;
        end
      end
      bms_pkg::BMS_START:
      begin
        if (s_reg.cnt <= 16'h0001)
        begin
          // Mid-bit confirm; a glitch returns to idle
          s_next.st = rxd ? bms_pkg::BMS_IDLE : bms_pkg::BMS_DATA;
          s_next.cnt = bit_cyc;
          s_next.idx = 3'h0;
        end
        else
          s_next.cnt = s_reg.cnt - 16'h0001;
      end
      bms_pkg::BMS_DATA:
      begin
        if (s_reg.cnt <= 16'h0001)
        begin
          s_next.sh = {rxd, s_reg.sh[7:1]};
          s_next.cnt = bit_cyc;
          s_next.idx = s_reg.idx + 3'h1;
          if (s_reg.idx == 3'h7)
            s_next.st = bms_pkg::BMS_STOP;
        end
        else
          s_next.cnt = s_reg.cnt - 16'h0001;
      end
      bms_pkg::BMS_STOP:
      begin
        if (s_reg.cnt <= 16'h0001)
        begin
          s_next.st = bms_pkg::BMS_IDLE;
          s_next.done = 1'b1;
          s_next.ferr = !rxd;
          s_next.data = s_reg.sh;
        end
        else
          s_next.cnt = s_reg.cnt - 16'h0001;
      end
      default:
        s_next.st = bms_pkg::BMS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '{st: bms_pkg::BMS_IDLE, cnt: 16'h0000, idx: 3'h0, sh: 8'h00,
                 rxd_d: 1'b1, done: 1'b0, ferr: 1'b0, data: 8'h00};
    end
    else if (ce)
      s_reg <= s_next;
  end

  assign done = s_reg.done;
  assign ferr = s_reg.ferr;
  assign data = s_reg.data;

  a_stop_frame: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && s_reg.st == bms_pkg::BMS_STOP && s_reg.cnt <= 16'h0001) |=> (done && ferr == !$past(rxd)))
    else $error("stop bit framing not reported");
endmodule

/* dv/bms_host.sv */
// Host side model: drives the serial line that opens the download
`timescale 1ns/100ps
module bms_host (
  input wire logic clk,
  output logic rxd
);
  initial rxd = 1'b1;
  // Start, data LSB first, stop; nb ends a frame early once only ones remain
  task automatic send(input logic [7:0] ch, input int cyc, input int nb);
    logic [9:0] fr;
    begin
      fr = {1'b1, ch, 1'b0};
      for (int i = 0; i < nb; i++)
      begin
        rxd <= fr[i];
        repeat (cyc) @(posedge clk);
      end
      rxd <= 1'b1;
    end
  endtask
endmodule

/* dv/bms_top_bench.sv */
// Self-checking bench for mode latch, vector relocation, registers and autobaud
`timescale 1ns/100ps
module bms_top_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin_a = 1'b0, pin_b = 1'b0, sec_dis = 1'b1, vec = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd_en = 1'b0, wr_en = 1'b0;
  logic ce = 1'b1;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic waitreq, rom_sel, exp_bit, spc_bit, boot_bit, slow, e, s, b;
  logic [15:0] mem_addr;
  wire rxd;
  int error_cnt = 0;
  int checks_done = 0;
  initial
  begin
    forever #20 clk = ~clk;
  end
  bms_host host (.clk(clk), .rxd(rxd));
  bms_top dut (.CORE_CLK(clk), .RESETN(rst_n), .CLK_EN(ce), .MODE_PIN_A(pin_a), .MODE_PIN_B(pin_b),
    .SECURITY_DISABLE_BIT(sec_dis), .RXD(rxd), .VEC_FETCH(vec), .CPU_ADDR(16'hFFFE),
    .AVS_ADDRESS(addr), .AVS_READ(rd_en), .AVS_WRITE(wr_en), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .MEM_ADDR(mem_addr),
    .BOOT_ROM_SEL(rom_sel), .EXPANDED_SELECT_BIT(exp_bit), .SPECIAL_SELECT_BIT(spc_bit),
    .BOOT_ROM_ENABLE_BIT(boot_bit), .SLOW_BAUD(slow));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checks_done++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic wrap_up();
    begin
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    begin
      n = 0;
      @(posedge clk);
      addr <= a;
      wdata <= wd;
      rd_en <= !w;
      wr_en <= w;
      do
      begin
        @(posedge clk);
        n++;
      end
      while (waitreq !== 1'b0 && n < 100);
      rd = rdata;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      if (waitreq !== 1'b0)
      begin
        error_cnt++;
        wrap_up();
      end
    end
  endtask
  task automatic rst(input logic [2:0] m);
    begin
      @(posedge clk);
      rst_n <= 1'b0;
      sec_dis <= m[2];
      pin_b <= m[1];
      pin_a <= m[0];
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
    end
  endtask
  initial
  begin
    for (int i = 0; i < 8; i++)
    begin
      rst(i[2:0]);
      e = i[0] & i[2];
      s = !i[1];
      b = s & !e;
      // Pins move after release; latched bits must not follow
      pin_a <= !i[0];
      pin_b <= !i[1];
      vec <= 1'b1;
      repeat (3) @(posedge clk);
      chk(exp_bit, e);
      chk(spc_bit, s);
      chk(boot_bit, b);
      chk(rom_sel, b);
      chk(mem_addr, s ? 16'hBFFE : 16'hFFFE);
      bus(1'b0, bms_pkg::OFS_MODE, 32'h0, d);
      chk(d, {28'h0, !i[2], b, s, e});
      vec <= 1'b0;
    end
    $display("test mode latch done");
    bus(1'b1, bms_pkg::OFS_MODE, 32'h7, d);
    bus(1'b0, bms_pkg::OFS_MODE, 32'h0, d);
    chk(d, 32'h1);
    rst(3'b101);
    bus(1'b1, bms_pkg::OFS_MODE, 32'h7, d);
    bus(1'b0, bms_pkg::OFS_MODE, 32'h0, d);
    chk(d, 32'h7);
    chk(boot_bit, 1'b1);
    bus(1'b1, bms_pkg::OFS_MODE, 32'h3, d);
    bus(1'b0, bms_pkg::OFS_MODE, 32'h0, d);
    chk(d, 32'h3);
    chk(rom_sel, 1'b0);
    chk(mem_addr, 16'hFFFE);
    bus(1'b0, 4'hC, 32'h0, d);
    chk(d, 32'h0);
    $display("test register writes done");
    // Straps wait for the enable after release
    ce <= 1'b0;
    rst(3'b100);
    chk(spc_bit, 1'b0);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    chk(spc_bit, 1'b1);
    chk(boot_bit, 1'b1);
    $display("test clock enable done");
    rst(3'b100);
    host.send(8'hFF, bms_pkg::BIT_CYC_FAST, 10);
    repeat (10) @(posedge clk);
    bus(1'b0, bms_pkg::OFS_BAUD, 32'h0, d);
    chk(d, 32'hA);
    bus(1'b0, bms_pkg::OFS_RXDATA, 32'h0, d);
    chk(d, 32'hFF);
    bus(1'b0, bms_pkg::OFS_BAUD, 32'h0, d);
    chk(d, 32'h2);
    chk(slow, 1'b0);
    $display("test fast first char done");
    rst(3'b100);
    // Slow all-ones frame: long start bit then high, enough for the fast receiver
    host.send(8'hFF, bms_pkg::BIT_CYC_SLOW, 2);
    bus(1'b0, bms_pkg::OFS_BAUD, 32'h0, d);
    chk(d, 32'hB);
    bus(1'b0, bms_pkg::OFS_RXDATA, 32'h0, d);
    chk(d & 32'hDF, 32'hC0);
    chk(slow, 1'b1);
    $display("test slow first char done");
    wrap_up();
  end
endmodule
